//--- include/sdhc_pkg.sv
// Package: register map, fields and timing of the card registers
package sdhc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_POWER  = 8'h00;
  localparam logic [7:0] OFS_CLOCK  = 8'h04;
  localparam logic [7:0] OFS_ARG    = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0c;
  localparam logic [7:0] OFS_RSPIDX = 8'h10;
  localparam logic [7:0] OFS_RSP1   = 8'h14;
  localparam logic [7:0] OFS_RSP4   = 8'h20;
  localparam logic [7:0] OFS_DTIMER = 8'h24;
  localparam logic [7:0] OFS_DLEN   = 8'h28;

  // ==========================================================================
  // Writable bit masks (reserved bits stay zero)
  localparam logic [31:0] POWER_MASK = 32'h0000_0003;
  localparam logic [31:0] CLOCK_MASK = 32'h0001_ffff;
  localparam logic [31:0] CMD_MASK   = 32'h0000_0fff;
  localparam logic [31:0] DLEN_MASK  = 32'h01ff_ffff;

  // ==========================================================================
  // Clock setup fields
  localparam int CK_DIV_HI = 15;
  localparam int CK_FLOW   = 14;
  localparam int CK_EDGE   = 13;
  localparam int CK_WIDTH  = 11;
  localparam int CK_BYPASS = 10;
  localparam int CK_PSAVE  = 9;
  localparam int CK_OE     = 8;

  // Command issue fields
  localparam int CM_SUSP     = 11;
  localparam int CM_ON       = 10;
  localparam int CM_WAITDATA = 9;
  localparam int CM_WAITIRQ  = 8;
  localparam int CM_RSP      = 6;

  // ==========================================================================
  // Codes and reset values
  localparam logic [1:0]  PWR_ON     = 2'h3;
  localparam logic [1:0]  RSP_SHORT  = 2'h1;
  localparam logic [1:0]  RSP_LONG   = 2'h3;
  localparam logic [1:0]  BUS_W4     = 2'h1;
  localparam logic [1:0]  BUS_W8     = 2'h2;
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;

  // ==========================================================================
  // Frame timing, in card clock periods
  localparam logic [7:0] CMD_BITS    = 8'h30;
  localparam logic [7:0] SHORT_BITS  = 8'h30;
  localparam logic [7:0] LONG_BITS   = 8'h88;
  localparam logic [6:0] RSP_TIMEOUT = 7'h40;

  // Command machine states, Gray along idle-pend-send-wait-recv
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_PEND = 3'b001,
    CS_SEND = 3'b011,
    CS_WAIT = 3'b010,
    CS_RECV = 3'b110
  } sdhc_cmd_state_t;

  // CRC7 over the 40 leading bits of a command frame
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = c[6] ^ d[i];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

endpackage

//--- rtl/sdhc_ckgen.sv
// Card clock divider with gating, bypass and edge selection
`timescale 1ns/1ns
module sdhc_ckgen (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Settings
  input  wire logic [9:0] div_i,
  input  wire logic       bypass_i,
  input  wire logic       edge_sel_i,
  input  wire logic       run_i,
  // Card clock
  output logic            card_clk_o,
  output logic            tick_o
);

  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic [10:0] period;
  logic        next_phase;

  // Period is divide value plus two
  always_comb begin
    period     = {1'b0, div_i} + 11'h002;
    next_cnt   = (cnt >= period - 11'h001) ? 11'h000 : cnt + 11'h001;
    next_phase = next_cnt < {1'b0, period[10:1]};
    if (bypass_i) begin
      // Fastest rate a registered output can give
      next_cnt   = {10'h000, ~cnt[0]};
      next_phase = ~cnt[0];
    end
  end

  // Stopped clock rests low and yields no ticks
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run_i) begin
      cnt        <= 11'h000;
      card_clk_o <= 1'b0;
      tick_o     <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      card_clk_o <= next_phase ^ edge_sel_i;
      tick_o     <= next_cnt == 11'h000;
    end
  end

endmodule

//--- rtl/sdhc_dtimer.sv
// Data timeout down-counter in card clock periods
`timescale 1ns/1ns
module sdhc_dtimer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         tick_i,
  input  wire logic         wait_i,
  input  wire logic [W-1:0] period_i,
  // Event
  output logic              timeout_o
);

  logic [W-1:0] count;
  logic         armed;
  logic         fired;

  // Load on entering wait, count card clocks there
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !wait_i) begin
      count <= '0;
      armed <= 1'b0;
    end else if (!armed) begin
      count <= period_i;
      armed <= 1'b1;
    end else if (tick_i && count != '0) begin
      count <= count - 1'b1;
    end
  end

  // One pulse per wait period at zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !wait_i) begin
      timeout_o <= 1'b0;
      fired     <= 1'b0;
    end else begin
      timeout_o <= armed && count == '0 && !fired;
      fired     <= fired || (armed && count == '0);
    end
  end

endmodule

//--- rtl/sdhc_regs.sv
// Card clock, command and response registers
// Function
// - Card clock is kernel clock over divide+2
// - Bypass drives card clock at half the kernel clock
// - Edge select picks card clock phase
// - Power saving gates clock when bus idle
// - Card clock driven only when output enabled
// - Bus width selects one, four, eight lines
// - Flow control bit enables hardware flow control
// - Read wait clock stop overrides clock settings
// - Six-bit command index sent in frame
// - Response kind: none, short or long
// - Command machine runs only while enabled
// - Optionally wait for data end first
// - Interrupt wait disables timeout, awaits card
// - Suspend marker flags an I/O suspend command
// - Capture index of last received response
// - Responses fill status words, MSB first
// - Data timer counts down in wait states
// - Length loaded into counter at transfer start
// - Response timeout after 64 card clocks
// - Power switch stops or starts card clock
`timescale 1ns/1ns
module sdhc_regs #(
  parameter int LEN_W = 25
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Register port, byte offsets
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [31:0]      reg_wdata_i,
  output logic [31:0]           reg_rdata_o,
  // Card link
  output logic                  card_clk_o,
  output logic                  card_clk_oe_o,
  input  wire logic             cmd_i,
  output logic                  cmd_o,
  output logic                  cmd_oe_o,
  input  wire logic             card_irq_n_i,
  // Data path handshake
  input  wire logic             data_busy_i,
  input  wire logic             data_wait_i,
  input  wire logic             data_start_i,
  input  wire logic             data_dec_i,
  input  wire logic             read_wait_stop_i,
  output logic [7:0]            data_lines_en_o,
  output logic                  flow_control_on_o,
  output logic [LEN_W-1:0]      data_count_o,
  // Events, one cycle each, and the command busy flag
  output logic                  cmd_sent_o,
  output logic                  rsp_done_o,
  output logic                  rsp_timeout_o,
  output logic                  suspend_ack_o,
  output logic                  card_irq_seen_o,
  output logic                  data_timeout_o,
  output logic                  cmd_active_o
);

  // ==========================================================================
  // Register storage
  logic [1:0]       power_switch_field;
  logic [16:0]      card_clock_setup;
  logic [31:0]      command_argument_word;
  logic [11:0]      command_issue;
  logic [5:0]       last_response_index;
  logic [31:0]      response_status_words [4];
  logic [31:0]      data_timeout_period;
  logic [LEN_W-1:0] data_byte_length;

  // Named fields of the clock setup and command issue
  logic [9:0] clock_divide_ratio;
  logic [1:0] bus_width_select;
  logic [1:0] response_kind;
  logic       command_machine_on;

  assign clock_divide_ratio = {card_clock_setup[16:15], card_clock_setup[7:0]};
  assign bus_width_select   = card_clock_setup[sdhc_pkg::CK_WIDTH +: 2];
  assign response_kind      = command_issue[sdhc_pkg::CM_RSP +: 2];
  assign command_machine_on = command_issue[sdhc_pkg::CM_ON];

  // ==========================================================================
  // Pin synchronisers
  logic cmd_meta;
  logic cmd_sync;
  logic irq_meta;
  logic irq_n_sync;

  // Two stages before logic reads a pin
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cmd_meta   <= 1'b1;
      cmd_sync   <= 1'b1;
      irq_meta   <= 1'b1;
      irq_n_sync <= 1'b1;
    end else begin
      cmd_meta   <= cmd_i;
      cmd_sync   <= cmd_meta;
      irq_meta   <= card_irq_n_i;
      irq_n_sync <= irq_meta;
    end
  end

  // ==========================================================================
  // Register writes
  logic cmd_write;

  // Command register write strobe
  assign cmd_write = reg_wr_i && reg_addr_i == sdhc_pkg::OFS_CMD;

  // Software spaces rewrites; there is no guard
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      power_switch_field    <= sdhc_pkg::REG_RESET[1:0];
      card_clock_setup      <= sdhc_pkg::REG_RESET[16:0];
      command_argument_word <= sdhc_pkg::REG_RESET;
      command_issue         <= sdhc_pkg::REG_RESET[11:0];
      data_timeout_period   <= sdhc_pkg::REG_RESET;
      data_byte_length      <= sdhc_pkg::REG_RESET[LEN_W-1:0];
    end else if (reg_wr_i) begin
      if (reg_addr_i == sdhc_pkg::OFS_POWER) begin
        power_switch_field <= reg_wdata_i[1:0];
      end else if (reg_addr_i == sdhc_pkg::OFS_CLOCK) begin
        card_clock_setup <= reg_wdata_i[16:0];
      end else if (reg_addr_i == sdhc_pkg::OFS_ARG) begin
        command_argument_word <= reg_wdata_i;
      end else if (cmd_write) begin
        command_issue <= reg_wdata_i[11:0];
      end else if (reg_addr_i == sdhc_pkg::OFS_DTIMER) begin
        data_timeout_period <= reg_wdata_i;
      end else if (reg_addr_i == sdhc_pkg::OFS_DLEN) begin
        data_byte_length <= reg_wdata_i[LEN_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Register reads, unmapped offsets read zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= sdhc_pkg::REG_RESET;
    end else if (reg_rd_i) begin
      if (reg_addr_i == sdhc_pkg::OFS_POWER) begin
        reg_rdata_o <= {30'h0000_0000, power_switch_field};
      end else if (reg_addr_i == sdhc_pkg::OFS_CLOCK) begin
        reg_rdata_o <= {15'h0000, card_clock_setup};
      end else if (reg_addr_i == sdhc_pkg::OFS_ARG) begin
        reg_rdata_o <= command_argument_word;
      end else if (reg_addr_i == sdhc_pkg::OFS_CMD) begin
        reg_rdata_o <= {20'h0_0000, command_issue};
      end else if (reg_addr_i == sdhc_pkg::OFS_RSPIDX) begin
        reg_rdata_o <= {26'h000_0000, last_response_index};
      end else if (reg_addr_i >= sdhc_pkg::OFS_RSP1 && reg_addr_i <= sdhc_pkg::OFS_RSP4
                   && reg_addr_i[1:0] == 2'h0) begin
        reg_rdata_o <= response_status_words[2'(reg_addr_i[7:2] - 6'h05)];
      end else if (reg_addr_i == sdhc_pkg::OFS_DTIMER) begin
        reg_rdata_o <= data_timeout_period;
      end else if (reg_addr_i == sdhc_pkg::OFS_DLEN) begin
        reg_rdata_o <= 32'(data_byte_length);
      end else begin
        reg_rdata_o <= sdhc_pkg::REG_RESET;
      end
    end
  end

  // ==========================================================================
  // Card clock
  sdhc_pkg::sdhc_cmd_state_t state;
  logic                      tick;
  logic                      bus_active;
  logic                      clk_run;

  // Bus is active during a command or data transfer
  assign bus_active = state != sdhc_pkg::CS_IDLE || data_busy_i;

  // Read wait stop overrides all; power and enable gate the rest
  assign clk_run = !read_wait_stop_i
                   && power_switch_field == sdhc_pkg::PWR_ON
                   && card_clock_setup[sdhc_pkg::CK_OE]
                   && (!card_clock_setup[sdhc_pkg::CK_PSAVE] || bus_active);

  sdhc_ckgen u_ckgen (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .div_i      (clock_divide_ratio),
    .bypass_i   (card_clock_setup[sdhc_pkg::CK_BYPASS]),
    .edge_sel_i (card_clock_setup[sdhc_pkg::CK_EDGE]),
    .run_i      (clk_run),
    .card_clk_o (card_clk_o),
    .tick_o     (tick)
  );

  // Clock pad drive follows enable and power
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      card_clk_oe_o     <= 1'b0;
      data_lines_en_o   <= 8'h00;
      flow_control_on_o <= 1'b0;
    end else begin
      card_clk_oe_o <= card_clock_setup[sdhc_pkg::CK_OE]
                       && power_switch_field == sdhc_pkg::PWR_ON;
      flow_control_on_o <= card_clock_setup[sdhc_pkg::CK_FLOW];
      if (bus_width_select == sdhc_pkg::BUS_W8) begin
        data_lines_en_o <= 8'hff;
      end else if (bus_width_select == sdhc_pkg::BUS_W4) begin
        data_lines_en_o <= 8'h0f;
      end else begin
        data_lines_en_o <= 8'h01;
      end
    end
  end

  // ==========================================================================
  // Command machine
  logic [47:0]  tx_shift;
  logic [127:0] rx_shift;
  logic [7:0]   bit_cnt;
  logic [6:0]   wait_cnt;
  logic [7:0]   rsp_bits;
  logic         go;
  logic [39:0]  frame_head;

  // Frame head: start, direction, index, argument
  assign frame_head = {2'b01, command_issue[5:0], command_argument_word};
  assign rsp_bits   = response_kind == sdhc_pkg::RSP_LONG ? sdhc_pkg::LONG_BITS
                                                          : sdhc_pkg::SHORT_BITS;

  // Start request held until the machine leaves idle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      go <= 1'b0;
    end else if (cmd_write && reg_wdata_i[sdhc_pkg::CM_ON]) begin
      go <= 1'b1;
    end else if (state != sdhc_pkg::CS_IDLE || !command_machine_on) begin
      go <= 1'b0;
    end
  end

  // Bit shifting happens only on card clock ticks
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !command_machine_on) begin
      state           <= sdhc_pkg::CS_IDLE;
      tx_shift        <= 48'hffff_ffff_ffff;
      rx_shift        <= '0;
      bit_cnt         <= 8'h00;
      wait_cnt        <= 7'h00;
      cmd_oe_o        <= 1'b0;
      cmd_sent_o      <= 1'b0;
      rsp_done_o      <= 1'b0;
      rsp_timeout_o   <= 1'b0;
      suspend_ack_o   <= 1'b0;
      card_irq_seen_o <= 1'b0;
    end else begin
      cmd_sent_o      <= 1'b0;
      rsp_done_o      <= 1'b0;
      rsp_timeout_o   <= 1'b0;
      suspend_ack_o   <= 1'b0;
      card_irq_seen_o <= 1'b0;
      case (state)
        sdhc_pkg::CS_IDLE: begin
          if (go) begin
            tx_shift <= {frame_head, sdhc_pkg::crc7(frame_head), 1'b1};
            bit_cnt  <= 8'h00;
            state    <= sdhc_pkg::CS_PEND;
          end
        end
        sdhc_pkg::CS_PEND: begin
          if (!(command_issue[sdhc_pkg::CM_WAITDATA] && data_busy_i)) begin
            state    <= sdhc_pkg::CS_SEND;
            cmd_oe_o <= 1'b1;
          end
        end
        sdhc_pkg::CS_SEND: begin
          if (tick) begin
            tx_shift <= {tx_shift[46:0], 1'b1};
            bit_cnt  <= bit_cnt + 8'h01;
            if (bit_cnt == sdhc_pkg::CMD_BITS - 8'h01) begin
              cmd_oe_o   <= 1'b0;
              cmd_sent_o <= 1'b1;
              wait_cnt   <= 7'h00;
              // Codes 00 and 10 expect nothing back
              state <= response_kind[0] ? sdhc_pkg::CS_WAIT
                                        : sdhc_pkg::CS_IDLE;
            end
          end
        end
        sdhc_pkg::CS_WAIT: begin
          if (tick && !cmd_sync) begin
            rx_shift <= {rx_shift[126:0], cmd_sync};
            bit_cnt  <= 8'h01;
            state    <= sdhc_pkg::CS_RECV;
          end else if (command_issue[sdhc_pkg::CM_WAITIRQ]) begin
            if (!irq_n_sync) begin
              card_irq_seen_o <= 1'b1;
              state           <= sdhc_pkg::CS_IDLE;
            end
          end else if (tick) begin
            wait_cnt <= wait_cnt + 7'h01;
            if (wait_cnt == sdhc_pkg::RSP_TIMEOUT - 7'h01) begin
              rsp_timeout_o <= 1'b1;
              state         <= sdhc_pkg::CS_IDLE;
            end
          end
        end
        sdhc_pkg::CS_RECV: begin
          if (tick) begin
            rx_shift <= {rx_shift[126:0], cmd_sync};
            bit_cnt  <= bit_cnt + 8'h01;
            if (bit_cnt == rsp_bits - 8'h01) begin
              rsp_done_o    <= 1'b1;
              suspend_ack_o <= command_issue[sdhc_pkg::CM_SUSP];
              state         <= sdhc_pkg::CS_IDLE;
            end
          end
        end
        default: begin
          state <= sdhc_pkg::CS_IDLE;
        end
      endcase
    end
  end

  // Command pin shows the frame's leading bit
  assign cmd_o = tx_shift[47];

  // Store the response after its end bit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      last_response_index <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        response_status_words[i] <= sdhc_pkg::REG_RESET;
      end
    end else if (rsp_done_o) begin
      // Long responses carry no index; rx_shift[45:40] is stored as the index anyway
      last_response_index <= rx_shift[45:40];
      if (response_kind == sdhc_pkg::RSP_LONG) begin
        response_status_words[0] <= rx_shift[127:96];
        response_status_words[1] <= rx_shift[95:64];
        response_status_words[2] <= rx_shift[63:32];
        response_status_words[3] <= {rx_shift[31:1], 1'b0};
      end else begin
        response_status_words[0] <= rx_shift[39:8];
      end
    end
  end

  // Busy flag for the data machine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cmd_active_o <= 1'b0;
    end else begin
      cmd_active_o <= state != sdhc_pkg::CS_IDLE;
    end
  end

  // ==========================================================================
  // Data timer and data counter
  sdhc_dtimer #(
    .W (32)
  ) u_dtimer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .wait_i    (data_wait_i),
    .period_i  (data_timeout_period),
    .timeout_o (data_timeout_o)
  );

  // Copy length at start, count down per byte
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      data_count_o <= '0;
    end else if (data_start_i) begin
      data_count_o <= data_byte_length;
    end else if (data_dec_i && data_count_o != '0) begin
      data_count_o <= data_count_o - 1'b1;
    end
  end

endmodule

//--- sim/sdhc_card_model.sv
// Card model: captures frames and answers them
`timescale 1ns/1ns
module sdhc_card_model (
  // Card link
  input  wire logic         card_clk_i,
  input  wire logic         cmd_oe_i,
  input  wire logic         cmd_i,
  output logic              cmd_o,
  // Scenario control
  input  wire logic [1:0]   kind_i,
  input  wire logic [135:0] rsp_i,
  output logic [47:0]       frame_o
);
  // ==========
  // Sample on the rising edge, as a card does
  always @(posedge card_clk_i) begin
    if (cmd_oe_i) begin
      frame_o <= {frame_o[46:0], cmd_i};
    end
  end
  // ==========
  // Answer after the host lets go; kind 3 is long
  initial begin
    cmd_o = 1'b1;
    forever begin
      @(negedge cmd_oe_i);
      if (kind_i[0] === 1'b1) begin
        repeat (4) @(negedge card_clk_i);
        for (int i = kind_i[1] ? 135 : 47; i >= 0; i--) begin
          cmd_o = rsp_i[i];
          @(negedge card_clk_i);
        end
        cmd_o = 1'b1; // Pull-up idles high
      end
    end
  end
endmodule

//--- sim/sdhc_regs_asserts.sv
// Checker: port-level timing of the register bank
`timescale 1ns/1ns
module sdhc_regs_asserts (
  // Clock, reset, writes
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        read_wait_stop_i,
  // Watched outputs
  input wire logic        card_clk_o,
  input wire logic        card_clk_oe_o,
  input wire logic        cmd_oe_o,
  input wire logic [7:0]  data_lines_en_o,
  input wire logic        flow_control_on_o,
  input wire logic        cmd_sent_o,
  input wire logic        rsp_done_o,
  input wire logic        rsp_timeout_o,
  input wire logic        suspend_ack_o
);
  logic [31:0] ck;
  logic [11:0] cm;
  logic [1:0]  pw;
  logic        ck_d;
  logic [7:0]  ticks;
  wire         wck = reg_wr_i && reg_addr_i == 8'h04;
  // ==========
  // Shadows of setup writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ck <= '0;
      cm <= '0;
      pw <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        8'h00: pw <= reg_wdata_i[1:0];
        8'h04: ck <= reg_wdata_i;
        8'h0c: cm <= reg_wdata_i[11:0];
        default: ;
      endcase
    end
  end
  // Card clock rises since last command, saturating
  always_ff @(posedge clk_sys_i) begin
    ck_d <= card_clk_o;
    if (!rst_n_i || cmd_sent_o) begin
      ticks <= 8'h00;
    end else if (card_clk_o && !ck_d && ticks != 8'hff) begin
      ticks <= ticks + 8'h01;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_RDW: assert property (read_wait_stop_i [*4] |-> !card_clk_o)
    else $error("clock in read wait");
  AST_PWR: assert property ((pw == 2'h0) [*4] |-> !card_clk_o)
    else $error("clock with power off");
  AST_OE: assert property (!ck[8] [*4] |-> !card_clk_oe_o)
    else $error("clock pad on while off");
  AST_LINES: assert property (wck |=> ##1 (ck[12:11] == 2'h3 || data_lines_en_o ==
    (ck[12:11] == 2'h0 ? 8'h01 : ck[11] ? 8'h0f : 8'hff))) else $error("wrong data lines");
  AST_FLOW: assert property (wck |=> ##1 flow_control_on_o == ck[14])
    else $error("flow control differs");
  AST_OFF: assert property (!cm[10] [*3] |-> !cmd_oe_o)
    else $error("command while off");
  AST_TO: assert property (rsp_timeout_o |-> ticks inside {[62:66]})
    else $error("timeout at wrong count");
  AST_IRQ: assert property (cm[8] |-> !rsp_timeout_o)
    else $error("timeout in irq wait");
  AST_SUSP: assert property (suspend_ack_o |-> rsp_done_o && cm[11])
    else $error("stray suspend ack");
endmodule
bind sdhc_regs sdhc_regs_asserts u_sdhc_regs_asserts (.*);

//--- sim/tb_top.sv
// Testbench: register bank against a card model
`timescale 1ns/1ns
module tb_top;
  logic         clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, card_irq_n_i, data_busy_i;
  logic         data_wait_i, data_start_i, data_dec_i, read_wait_stop_i, card_cmd;
  logic         card_clk_o, card_clk_oe_o, cmd_o, cmd_oe_o, flow_control_on_o;
  logic         cmd_sent_o, rsp_done_o, rsp_timeout_o, suspend_ack_o, card_irq_seen_o;
  logic         data_timeout_o, cmd_active_o;
  logic [7:0]   reg_addr_i, data_lines_en_o;
  logic [31:0]  reg_wdata_i, reg_rdata_o, seed, rd_v, d;
  logic [24:0]  data_count_o;
  logic [1:0]   mkind;
  logic [135:0] mrsp;
  logic [47:0]  frame;
  int           n_errors, total_checks, cyc;
  wire          cmd_i = cmd_oe_o ? cmd_o : card_cmd;
  wire  [4:0]   ev = {data_timeout_o, card_irq_seen_o, rsp_timeout_o, rsp_done_o, cmd_sent_o};
  localparam logic [7:0]  OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h24, 8'h28};
  localparam logic [31:0] MSK [7] = '{sdhc_pkg::POWER_MASK, sdhc_pkg::CLOCK_MASK, '1,
    sdhc_pkg::CMD_MASK, '0, '1, sdhc_pkg::DLEN_MASK};
  sdhc_regs u_sdhc_regs (.*);
  sdhc_card_model u_sdhc_card_model (.card_clk_i(card_clk_o), .cmd_oe_i(cmd_oe_o),
    .cmd_i(cmd_o), .cmd_o(card_cmd), .kind_i(mkind), .rsp_i(mrsp), .frame_o(frame));
  // ==========
  // Clock and hang guard
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Writes leave seven idle cycles behind
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i) #1;
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(posedge clk_sys_i) #1;
    reg_wr_i = 1'b0;
    repeat (7) @(posedge clk_sys_i) #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i) #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_sys_i) #1;
    reg_rd_i = 1'b0;
    rd_v = reg_rdata_o;
  endtask
  task automatic wt(input int b);
    for (int i = 0; i < 3000 && !ev[b]; i++) begin
      @(posedge clk_sys_i) #1;
    end
    chk(ev[b], 1'b1);
  endtask
  // One command; mk sets the card answer, f is {suspend, wait data, wait irq}
  task automatic run_cmd(input logic [1:0] k, input logic [1:0] mk, input logic [2:0] f);
    logic [5:0]   ix;
    logic [31:0]  ar, st;
    logic [127:0] pl;
    ix = 6'(rnd());
    ar = rnd();
    st = rnd();
    pl = {rnd(), rnd(), rnd(), rnd()};
    mrsp = k == 2'h3 ? {8'h3f, pl[127:1], 1'b1} : {88'h0, 2'b00, ix, st, 8'h01};
    mkind = mk;
    data_busy_i = f[1];
    wr(8'h08, ar);
    wr(8'h0c, {20'h0, f[2], 1'b1, f[1:0], k, ix});
    if (f[1]) begin
      repeat (40) @(posedge clk_sys_i) #1;
      chk(cmd_oe_o, 1'b0);
      data_busy_i = 1'b0;
    end
    wt(0);
    chk(frame & 48'hffffffffff01, {2'b01, ix, ar, 8'h01});
    if (!k[0]) return;
    if (f[0]) begin
      repeat (200) @(posedge clk_sys_i) #1;
      card_irq_n_i = 1'b0;
      wt(3);
      card_irq_n_i = 1'b1;
    end else if (mk == 2'h0) begin
      wt(2);
    end else begin
      wt(1);
      chk(suspend_ack_o, f[2]);
      rd(8'h14);
      chk(rd_v, k[1] ? pl[127:96] : st);
      rd(k[1] ? 8'h20 : 8'h10);
      chk(rd_v, k[1] ? {pl[31:1], 1'b0} : {26'h0, ix});
    end
  endtask
  task automatic per(input logic [31:0] v, input int e);
    time t0;
    wr(8'h04, v);
    @(posedge card_clk_o);
    t0 = $time;
    @(posedge card_clk_o);
    chk(($time - t0) / 10, e);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    {clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, data_busy_i, data_wait_i} = '0;
    {data_start_i, data_dec_i, read_wait_stop_i, mkind, mrsp} = '0;
    {reg_addr_i, reg_wdata_i} = '0;
    card_irq_n_i = 1'b1;
    seed = 32'h06b142f3;
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    for (int a = 0; a <= 'h40; a += 4) begin
      rd(8'(a));
      chk(rd_v, 32'h0);
    end
    foreach (OFFS[i]) begin
      d = rnd() & ~32'h400;
      wr(OFFS[i], d);
      rd(OFFS[i]);
      chk(rd_v, d & MSK[i]);
    end
    chk(cmd_active_o, 1'b0);
    data_start_i = 1'b1;
    @(posedge clk_sys_i) #1;
    data_start_i = 1'b0;
    data_dec_i = 1'b1;
    chk(data_count_o, d[24:0]);
    @(posedge clk_sys_i) #1;
    data_dec_i = 1'b0;
    chk(data_count_o, d[24:0] - 25'h1);
    wr(8'h00, 32'h3);
    for (int w = 0; w < 3; w++) begin
      wr(8'h04, {17'h0, w[0], 1'b0, w[1:0], 3'b001, 8'h06});
      chk(data_lines_en_o, w == 0 ? 8'h01 : w == 1 ? 8'h0f : 8'hff);
      chk(flow_control_on_o, w[0]);
    end
    for (int k = 0; k < 4; k++) begin
      run_cmd(2'(k), 2'(k), 3'h0);
    end
    run_cmd(2'h1, 2'h0, 3'h0);
    run_cmd(2'h1, 2'h0, 3'h1);
    run_cmd(2'h1, 2'h1, 3'h4);
    run_cmd(2'h3, 2'h3, 3'h2);
    wr(8'h04, 32'h306);
    repeat (20) @(posedge clk_sys_i);
    chk(card_clk_o, 1'b0);
    per(32'h0000_0106, 8);
    per(32'h0000_8100, 258);
    per(32'h0000_0500, 2);
    wr(8'h24, 32'h5);
    data_wait_i = 1'b1;
    wt(4);
    data_wait_i = 1'b0;
    read_wait_stop_i = 1'b1;
    repeat (20) @(posedge clk_sys_i) #1;
    chk(card_clk_o, 1'b0);
    read_wait_stop_i = 1'b0;
    wr(8'h00, 32'h0);
    chk(card_clk_o, 1'b0);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h6);
    chk(card_clk_oe_o, 1'b0);
    print_verdict();
  end
endmodule
